/* dio_pkg.sv */
package dio_pkg;

    // data path and local offset widths
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          CHAN_W        = 64;

    // data register offsets relative to the assigned i/o base
    localparam logic [7:0]  OFS_IO_LOW    = 8'h00;
    localparam logic [7:0]  OFS_IO_HIGH   = 8'h04;
    localparam logic [7:0]  OFS_CLR_64IN  = 8'h08;
    localparam logic [7:0]  OFS_CLR_32IO  = 8'h40;

    // config header offsets of the two base address slots
    localparam logic [7:0]  CFG_OFS_LOCAL = 8'h14;
    localparam logic [7:0]  CFG_OFS_IO    = 8'h18;

    // base slots decode 128 bytes of i/o space, bit 0 marks i/o
    localparam logic [31:0] BAR_ADDR_MASK = 32'hffffff80;
    localparam logic [31:0] BAR_IO_FLAG   = 32'h00000001;
    localparam logic [31:0] BAR_RESET     = 32'h00000001;

    // channel enable masks per word
    localparam logic [31:0] MASK_16       = 32'h0000ffff;
    localparam logic [31:0] MASK_ALL      = 32'hffffffff;
    localparam logic [31:0] MASK_NONE     = 32'h00000000;
    localparam logic [31:0] OUT_RESET     = 32'h00000000;
    localparam logic [31:0] READ_ZERO     = 32'h00000000;

    // card variants
    typedef enum logic [1:0] {
        var_16_16  = 2'b00,
        var_32_32  = 2'b01,
        var_64_in  = 2'b11,
        var_64_out = 2'b10
    } variant_t;

    // register port handshake states
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_done = 2'b01
    } bus_state_t;

    // one access from the bridge, full 32-bit words only
    typedef struct packed {
        logic                 rd;
        logic                 wr;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
    } acc_req_t;

    // state of the data register port
    typedef struct packed {
        bus_state_t           bus;
        logic                 ack;
        logic [DATA_W-1:0]    rdata;
        logic                 irq;
    } port_state_t;

    // state of the config header slots
    typedef struct packed {
        logic [DATA_W-1:0]    bar_local;
        logic [DATA_W-1:0]    bar_io;
        logic                 ack;
        logic [DATA_W-1:0]    rdata;
    } cfg_state_t;

endpackage

/* dio_out_word.sv */
`timescale 1ns/100ps

// one 32-bit output latch word
module dio_out_word #(
    parameter logic [31:0] MASK = 32'hffffffff
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        load,
    input  wire logic [31:0] wdata,
    output logic      [31:0] q_r
);
    import dio_pkg::*;

    logic [31:0] q_nxt;

    // keeps the last written value until the next write or reset
    always_comb begin
        q_nxt = q_r;
        if (load) begin
            q_nxt = wdata & MASK;
        end
    end

    // outputs come up off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q_r <= OUT_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule // dio_out_word

/* dio_cfg_header.sv */
`timescale 1ns/100ps

// base address slots of the config header
module dio_cfg_header (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire dio_pkg::acc_req_t        cfg_req,
    output logic                          cfg_ack,
    output logic      [dio_pkg::DATA_W-1:0] cfg_rdata,
    output logic      [dio_pkg::DATA_W-1:0] local_bridge_config_base,
    output logic      [dio_pkg::DATA_W-1:0] io_base
);
    import dio_pkg::*;

    cfg_state_t st_r;
    cfg_state_t st_nxt;

    // firmware writes the slots, any cycle, answer one cycle later
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ack   = cfg_req.rd | cfg_req.wr;
        st_nxt.rdata = READ_ZERO;
        if (cfg_req.wr && cfg_req.addr == CFG_OFS_LOCAL) begin
            st_nxt.bar_local = (cfg_req.wdata & BAR_ADDR_MASK) | BAR_IO_FLAG;
        end
        if (cfg_req.wr && cfg_req.addr == CFG_OFS_IO) begin
            st_nxt.bar_io = (cfg_req.wdata & BAR_ADDR_MASK) | BAR_IO_FLAG;
        end
        if (cfg_req.rd) begin
            case (cfg_req.addr)
                CFG_OFS_LOCAL: st_nxt.rdata = st_r.bar_local;
                CFG_OFS_IO:    st_nxt.rdata = st_r.bar_io;
                default:       st_nxt.rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '{bar_local: BAR_RESET, bar_io: BAR_RESET, ack: 1'b0, rdata: READ_ZERO};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cfg_ack                  = st_r.ack;
    assign cfg_rdata                = st_r.rdata;
    assign local_bridge_config_base = st_r.bar_local;
    assign io_base                  = st_r.bar_io;

    a_io_base_read: assert property (@(posedge clk) disable iff (!nrst)
        cfg_req.rd && cfg_req.addr == CFG_OFS_IO |=> cfg_ack && cfg_rdata == $past(io_base))
        else $error("io base slot read back wrong");

endmodule // dio_cfg_header

/* dio_port.sv */
`timescale 1ns/100ps

module dio_port #(
    parameter dio_pkg::variant_t VARIANT = dio_pkg::var_32_32
) (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire dio_pkg::acc_req_t          lb_req,
    output logic                            lb_ack,
    output logic      [dio_pkg::DATA_W-1:0] lb_rdata,
    input  wire dio_pkg::acc_req_t          cfg_req,
    output logic                            cfg_ack,
    output logic      [dio_pkg::DATA_W-1:0] cfg_rdata,
    output logic      [dio_pkg::DATA_W-1:0] local_bridge_config_base,
    output logic      [dio_pkg::DATA_W-1:0] io_base,
    input  wire logic                       irq_event,
    output logic                            irq_pending,
    input  wire logic [dio_pkg::CHAN_W-1:0] isolated_input_channel,
    output logic      [dio_pkg::CHAN_W-1:0] isolated_output_channel
);
    import dio_pkg::*;

    // channel masks and interrupt clear location per variant
    localparam logic [31:0] OUT_MASK_LO = (VARIANT == var_16_16) ? MASK_16 :
                                          (VARIANT == var_64_in) ? MASK_NONE : MASK_ALL;
    localparam logic [31:0] OUT_MASK_HI = (VARIANT == var_64_out) ? MASK_ALL : MASK_NONE;
    localparam logic [31:0] IN_MASK_LO  = (VARIANT == var_16_16) ? MASK_16 :
                                          (VARIANT == var_64_out) ? MASK_NONE : MASK_ALL;
    localparam logic [31:0] IN_MASK_HI  = (VARIANT == var_64_in) ? MASK_ALL : MASK_NONE;
    localparam logic        HAS_CLR     = (VARIANT == var_32_32) || (VARIANT == var_64_in);
    localparam logic [7:0]  OFS_CLR     = (VARIANT == var_64_in) ? OFS_CLR_64IN : OFS_CLR_32IO;

    port_state_t        st_r;
    port_state_t        st_nxt;
    logic               take;
    logic               wr_take;
    logic               rd_take;
    logic               load_lo;
    logic               load_hi;
    logic               clr_hit;
    logic [DATA_W-1:0]  in_lo;
    logic [DATA_W-1:0]  in_hi;
    logic [DATA_W-1:0]  out_lo;
    logic [DATA_W-1:0]  out_hi;

    // a request is taken only from idle; the port never starts a cycle itself
    assign take    = (st_r.bus == bus_idle) && (lb_req.rd || lb_req.wr);
    assign wr_take = take && lb_req.wr;
    assign rd_take = take && lb_req.rd && !lb_req.wr;

    // channel i of the low word is bit i, high word carries channels 32 up
    assign in_lo = isolated_input_channel[31:0] & IN_MASK_LO;
    assign in_hi = isolated_input_channel[63:32] & IN_MASK_HI;

    // write decode: output words only exist where the variant has outputs
    assign load_lo = wr_take && (lb_req.addr == OFS_IO_LOW) && (OUT_MASK_LO != MASK_NONE);
    assign load_hi = wr_take && (lb_req.addr == OFS_IO_HIGH) && (OUT_MASK_HI != MASK_NONE);
    assign clr_hit = HAS_CLR && wr_take && (lb_req.addr == OFS_CLR);

    // low output word, channels 0 to 31
    dio_out_word #(
        .MASK  (OUT_MASK_LO)
    ) u_out_lo (
        .clk   (clk),
        .nrst  (nrst),
        .load  (load_lo),
        .wdata (lb_req.wdata),
        .q_r   (out_lo)
    );

    // high output word, channels 32 to 63
    dio_out_word #(
        .MASK  (OUT_MASK_HI)
    ) u_out_hi (
        .clk   (clk),
        .nrst  (nrst),
        .load  (load_hi),
        .wdata (lb_req.wdata),
        .q_r   (out_hi)
    );

    // config header base address slots
    dio_cfg_header u_cfg (
        .clk                      (clk),
        .nrst                     (nrst),
        .cfg_req                  (cfg_req),
        .cfg_ack                  (cfg_ack),
        .cfg_rdata                (cfg_rdata),
        .local_bridge_config_base (local_bridge_config_base),
        .io_base                  (io_base)
    );

    // access handshake, read mux and interrupt pending latch
    always_comb begin
        st_nxt       = st_r;
        st_nxt.ack   = 1'b0;
        case (st_r.bus)
            bus_idle: begin
                if (take) begin
                    st_nxt.bus   = bus_done;
                    st_nxt.ack   = 1'b1;
                    st_nxt.rdata = READ_ZERO;
                end
                if (rd_take) begin
                    // every location is one 32-bit word
                    case (lb_req.addr)
                        OFS_IO_LOW:  st_nxt.rdata = in_lo;
                        OFS_IO_HIGH: st_nxt.rdata = in_hi;
                        default:     st_nxt.rdata = READ_ZERO;
                    endcase
                end
            end
            bus_done: begin
                st_nxt.bus = bus_idle;
            end
            default: begin
                st_nxt.bus = bus_idle;
            end
        endcase
        // a new event in the clearing cycle keeps the request pending
        st_nxt.irq = irq_event | (st_r.irq & !clr_hit);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '{bus: bus_idle, ack: 1'b0, rdata: READ_ZERO, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lb_ack                  = st_r.ack;
    assign lb_rdata                = st_r.rdata;
    assign irq_pending             = st_r.irq;
    assign isolated_output_channel = {out_hi, out_lo};

    // a write at the base drives the low channels on the next edge
    a_low_write_out: assert property (@(posedge clk) disable iff (!nrst)
        wr_take && lb_req.addr == OFS_IO_LOW
        |=> isolated_output_channel[31:0] == ($past(lb_req.wdata) & OUT_MASK_LO))
        else $error("low output word not loaded from write");

    // a write at 0x04 drives the high channels, low word untouched
    a_high_write_out: assert property (@(posedge clk) disable iff (!nrst)
        wr_take && lb_req.addr == OFS_IO_HIGH
        |=> isolated_output_channel[63:32] == ($past(lb_req.wdata) & OUT_MASK_HI)
            && $stable(isolated_output_channel[31:0]))
        else $error("high output word wrong after write");

    // a read at the base returns the sampled input channels with the answer
    a_low_read_in: assert property (@(posedge clk) disable iff (!nrst)
        rd_take && lb_req.addr == OFS_IO_LOW
        |=> lb_ack && lb_rdata == ($past(isolated_input_channel[31:0]) & IN_MASK_LO))
        else $error("low input read mismatch");

    // the high input word reads only on the 64-input card
    a_high_read_in: assert property (@(posedge clk) disable iff (!nrst)
        rd_take && lb_req.addr == OFS_IO_HIGH
        |=> lb_rdata == ((VARIANT == var_64_in) ? $past(isolated_input_channel[63:32]) : READ_ZERO))
        else $error("high input read mismatch");

    // clear locations and unused offsets read as zero
    a_unused_read_zero: assert property (@(posedge clk) disable iff (!nrst)
        rd_take && lb_req.addr != OFS_IO_LOW && lb_req.addr != OFS_IO_HIGH
        |=> lb_ack && lb_rdata == READ_ZERO)
        else $error("unused location read not zero");

    // outputs hold while no output write is taken
    a_out_hold: assert property (@(posedge clk) disable iff (!nrst)
        !load_lo && !load_hi |=> $stable(isolated_output_channel))
        else $error("outputs moved without a write");

    // clearing with no new event drops the request; an event always wins
    a_irq_clear: assert property (@(posedge clk) disable iff (!nrst)
        clr_hit && !irq_event |=> !irq_pending)
        else $error("interrupt not cleared");

    a_irq_event_wins: assert property (@(posedge clk) disable iff (!nrst)
        irq_event |=> irq_pending)
        else $error("interrupt event lost");

    // each access gets exactly one answer pulse, and the next waits a cycle
    a_ack_single: assert property (@(posedge clk) disable iff (!nrst)
        take |=> lb_ack ##1 !lb_ack)
        else $error("answer pulse not single");

endmodule // dio_port

/* host_model.sv */
`timescale 1ns/100ps

// bridge local side standing in for the host: masters every access
module host_model (
    input  wire logic                       clk,
    output dio_pkg::acc_req_t               lb_req,
    input  wire logic                       lb_ack,
    input  wire logic [dio_pkg::DATA_W-1:0] lb_rdata,
    output dio_pkg::acc_req_t               cfg_req,
    input  wire logic                       cfg_ack,
    input  wire logic [dio_pkg::DATA_W-1:0] cfg_rdata
);
    import dio_pkg::*;

    // both ports idle from time zero
    initial begin
        lb_req  = '0;
        cfg_req = '0;
    end

    // one word access: one-cycle strobe, then the answer is taken in the ack cycle
    task automatic acc(input logic cfg, input logic rd, input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic ok);
        acc_req_t r;
        r = '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge clk);
        if (cfg) begin
            cfg_req <= r;
        end else begin
            lb_req <= r;
        end
        @(posedge clk);
        // released lines carry the inverse so stale values never look valid
        r = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        if (cfg) begin
            cfg_req <= r;
        end else begin
            lb_req <= r;
        end
        @(negedge clk);
        ok = cfg ? cfg_ack : lb_ack;
        q  = cfg ? cfg_rdata : lb_rdata;
    endtask

endmodule // host_model

/* tb.sv */
`timescale 1ns/100ps

module tb;
    import dio_pkg::*;

    logic        clk;
    logic        nrst;
    logic        irq_event;
    logic        irq_pending;
    logic [63:0] in_ch;
    logic [63:0] out_ch;
    acc_req_t    lb_req;
    acc_req_t    cfg_req;
    logic        lb_ack;
    logic        cfg_ack;
    logic [31:0] lb_rdata;
    logic [31:0] cfg_rdata;
    logic [31:0] lbase;
    logic [31:0] io_base;
    int          n_fail;
    int          compares;
    logic [63:0] out16;
    logic [63:0] out64i;
    logic [63:0] out64o;
    logic [31:0] rd16;
    logic [31:0] rd64i;
    logic [31:0] rd64o;
    logic        irq16;
    logic        irq64i;
    logic        irq64o;

    dio_port #(.VARIANT(var_32_32)) dio_port_inst (
        .clk(clk), .nrst(nrst), .lb_req(lb_req), .lb_ack(lb_ack), .lb_rdata(lb_rdata),
        .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .local_bridge_config_base(lbase), .io_base(io_base), .irq_event(irq_event),
        .irq_pending(irq_pending), .isolated_input_channel(in_ch), .isolated_output_channel(out_ch)
    );

    // the other card variants follow the same requests in lockstep
    dio_port #(.VARIANT(var_16_16)) dio_port_inst_16 (
        .clk(clk), .nrst(nrst), .lb_req(lb_req), .lb_ack(), .lb_rdata(rd16),
        .cfg_req(cfg_req), .cfg_ack(), .cfg_rdata(),
        .local_bridge_config_base(), .io_base(), .irq_event(irq_event),
        .irq_pending(irq16), .isolated_input_channel(in_ch), .isolated_output_channel(out16)
    );

    dio_port #(.VARIANT(var_64_in)) dio_port_inst_64in (
        .clk(clk), .nrst(nrst), .lb_req(lb_req), .lb_ack(), .lb_rdata(rd64i),
        .cfg_req(cfg_req), .cfg_ack(), .cfg_rdata(),
        .local_bridge_config_base(), .io_base(), .irq_event(irq_event),
        .irq_pending(irq64i), .isolated_input_channel(in_ch), .isolated_output_channel(out64i)
    );

    dio_port #(.VARIANT(var_64_out)) dio_port_inst_64out (
        .clk(clk), .nrst(nrst), .lb_req(lb_req), .lb_ack(), .lb_rdata(rd64o),
        .cfg_req(cfg_req), .cfg_ack(), .cfg_rdata(),
        .local_bridge_config_base(), .io_base(), .irq_event(irq_event),
        .irq_pending(irq64o), .isolated_input_channel(in_ch), .isolated_output_channel(out64o)
    );

    host_model host_model_inst (
        .clk(clk), .lb_req(lb_req), .lb_ack(lb_ack), .lb_rdata(lb_rdata),
        .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata)
    );

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one access through the host with answer and read data checks
    task automatic acc(input logic cfg, input logic rd, input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] exp);
        logic [31:0] q;
        logic        ok;
        host_model_inst.acc(cfg, rd, wr, a, d, q, ok);
        chk(cfg ? "cfg_ack" : "lb_ack", 64'h1, {63'h0, ok});
        if (rd || !cfg) begin
            chk(cfg ? "cfg_rdata" : "lb_rdata", {32'h0, exp}, {32'h0, q});
        end
    endtask

    // verdict and end of run
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        test_done;
    end

    // test sequence
    initial begin
        n_fail = 0;
        compares = 0;
        nrst <= 1'b0;
        irq_event <= 1'b0;
        in_ch <= 64'h0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("outputs", 64'h0, out_ch);
        chk("outputs_64out", 64'h0, out64o);
        chk("irq_pending", 64'h0, {63'h0, irq_pending});
        chk("io_base", 64'h1, {32'h0, io_base});
        chk("local_base", 64'h1, {32'h0, lbase});
        $display("test reset done");
        // base slots of the config header
        acc(1'b1, 1'b0, 1'b1, 8'h18, 32'h123456ff, 32'h0);
        chk("io_base", 64'h12345681, {32'h0, io_base});
        acc(1'b1, 1'b0, 1'b1, 8'h14, 32'hcafe0042, 32'h0);
        chk("local_base", 64'hcafe0001, {32'h0, lbase});
        acc(1'b1, 1'b1, 1'b0, 8'h18, 32'h0, 32'h12345681);
        acc(1'b1, 1'b1, 1'b0, 8'h14, 32'h0, 32'hcafe0001);
        acc(1'b1, 1'b1, 1'b0, 8'h10, 32'h0, 32'h0);
        $display("test config done");
        // outputs and inputs at offsets 0 and 4, then a read of the clear location at 0x40
        in_ch <= 64'hffff0000a5c30f01;
        acc(1'b0, 1'b0, 1'b1, 8'h00, 32'h80000001, 32'h0);
        chk("outputs", 64'h0000000080000001, out_ch);
        chk("outputs_16", 64'h0000000000000001, out16);
        chk("outputs_64in", 64'h0, out64i);
        chk("outputs_64out", 64'h0000000080000001, out64o);
        acc(1'b0, 1'b1, 1'b0, 8'h00, 32'h0, 32'ha5c30f01);
        chk("rdata_16", 64'h0000000000000f01, {32'h0, rd16});
        chk("rdata_64in", 64'h00000000a5c30f01, {32'h0, rd64i});
        chk("rdata_64out", 64'h0, {32'h0, rd64o});
        acc(1'b0, 1'b0, 1'b1, 8'h04, 32'hffffffff, 32'h0);
        chk("outputs_64out", 64'hffffffff80000001, out64o);
        chk("outputs_16", 64'h0000000000000001, out16);
        acc(1'b0, 1'b1, 1'b0, 8'h04, 32'h0, 32'h0);
        chk("rdata_64in", 64'h00000000ffff0000, {32'h0, rd64i});
        acc(1'b0, 1'b1, 1'b0, 8'h40, 32'h0, 32'h0);
        chk("outputs", 64'h0000000080000001, out_ch);
        $display("test data done");
        // pending interrupt and its clear location
        @(posedge clk);
        irq_event <= 1'b1;
        @(posedge clk);
        irq_event <= 1'b0;
        @(negedge clk);
        chk("irq_pending", 64'h1, {63'h0, irq_pending});
        chk("irq_pending_64in", 64'h1, {63'h0, irq64i});
        acc(1'b0, 1'b0, 1'b1, 8'h08, 32'h0, 32'h0);
        chk("irq_pending", 64'h1, {63'h0, irq_pending});
        chk("irq_pending_64in", 64'h0, {63'h0, irq64i});
        acc(1'b0, 1'b0, 1'b1, 8'h40, 32'h0, 32'h0);
        chk("irq_pending", 64'h0, {63'h0, irq_pending});
        chk("irq_pending_16", 64'h1, {63'h0, irq16});
        $display("test interrupt done");
        // reset in mid-run turns outputs off
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("outputs", 64'h0, out_ch);
        chk("outputs_64out", 64'h0, out64o);
        chk("outputs_16", 64'h0, out16);
        $display("test rerun reset done");
        test_done;
    end

endmodule // tb
